// File: include/hbi_defs.vh
/*
 * Constants of the host bus interface and internal bus arbiter:
 * register offsets, field positions, reset values, mode codes and bus commands.
 * Assumes inclusion by bare name from the design files under core/.
 */
`ifndef HBI_DEFS_VH
`define HBI_DEFS_VH

// Global registers (byte addresses)
`define OFF_CONFIG 8'h00
`define OFF_STATUS 8'h04
`define OFF_INT_CLEAR 8'h08
`define OFF_INT_ENABLE 8'h0c
`define OFF_MODE 8'h10

// Per-core register sets: base plus core index times stride
`define OFF_CORE_BASE 8'h40
`define CORE_REGION_MASK 8'hc0
`define OFF_CORE_CTRL 4'h0
`define OFF_RX_CHAN_EN 4'h4
`define OFF_TX_CHAN_EN 4'h8
`define OFF_XFER_COUNT 4'hc

// Fields
`define CFG_BURST_EN_BIT 0
`define CTRL_CORE_EN_BIT 0
`define ST_DONE_BIT 0
`define ST_REFUSED_BIT 1
`define ST_BITS_PER_CORE 2

// Reset values
`define CONFIG_RESET 32'h0000_0001
`define CTRL_RESET 32'h0000_0001
`define CHAN_EN_RESET 32'hffff_ffff
`define STATUS_RESET 8'h00
`define INT_ENABLE_RESET 8'h00

// Mode select pin codes
`define MODE_PCI 2'h0
`define MODE_DEMULTIPLEXED_BUS_MODE 2'h1

// Host bus command nibbles for PCI mode
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_READ_MULT 4'hc

`endif

// File: core/rr_arbiter.v
/*
 * Round-robin arbiter with a registered one-hot grant held until the
 * granted transfer ends. Assumes requests stay high until granted.
 */
`timescale 1ns/1ps
module rr_arbiter #(
    parameter N = 4,
    parameter W = 2
)(
    input wire mclk, // System clock
    input wire sys_rst, // Asynchronous reset, active high
    input wire [N-1:0] req, // Request per master
    input wire xfer_end, // Granted transfer has ended
    output reg [N-1:0] gnt // One-hot grant
);
    reg [W-1:0] ptr_reg;
    reg [W-1:0] gnt_idx_reg;
    reg [N-1:0] pick;
    reg [W-1:0] pick_idx;
    reg found;
    integer i;
    integer k;

    // First requester at or after the priority pointer
    always @*
    begin
        pick = {N{1'b0}};
        pick_idx = {W{1'b0}};
        found = 1'b0;
        k = 0;
        for (i = 0; i < N; i = i + 1)
        begin
            k = (ptr_reg + i) % N;
            if (!found && req[k])
            begin
                pick[k] = 1'b1;
                pick_idx = k[W-1:0];
                found = 1'b1;
            end
        end
    end

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gnt <= {N{1'b0}};
            ptr_reg <= {W{1'b0}};
            gnt_idx_reg <= {W{1'b0}};
        end
        else if (gnt != {N{1'b0}})
        begin
            if (xfer_end)
            begin
                gnt <= {N{1'b0}};
                ptr_reg <= gnt_idx_reg + 1'b1;
            end
        end
        else if (found)
        begin
            gnt <= pick;
            gnt_idx_reg <= pick_idx;
        end
    end
endmodule // rr_arbiter

// File: core/host_bus_interface_arbiter.v
/*
 * Global host-side logic: round-robin access of four DMA masters to the
 * internal bus, a host bus master engine for PCI or demultiplexed mode,
 * and the Wishbone register slave with per-core sets and a shared status.
 * Assumes DMA masters run on mclk; host bus pins are asynchronous inputs.
 */
`timescale 1ns/1ps
`include "hbi_defs.vh"

// Operation
// - Round-robin arbiter shares the internal bus fairly among four DMA masters.
// - Internal bus is 32-bit synchronous; payload data moves as single accesses.
// - Descriptor transfers use burst transactions on the internal bus.
// - Two mode-select pins choose PCI or demultiplexed host bus operation.
// - In demultiplexed mode one write-not-read signal replaces the command nibble.
// - As burst master only the start address is driven; target advances it.
// - Clearing the burst-enable bit stops burst master transactions.
// - Every payload and descriptor transfer is done with the device as master.
// - Host software reaches any register of any core as bus slave.
// - Four identical per-core register sets, differing only by offset.
// - One shared status register records events of all four cores.
// - Each core has 32 receive and 32 transmit DMA channels.
module host_bus_interface_arbiter #(
    parameter NCORE = 4,
    parameter NCHAN = 32,
    parameter LENW = 3
)(
    input wire mclk, // System clock, 50 MHz
    input wire sys_rst, // Asynchronous reset, active high
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write enable
    input wire [7:0] wb_adr_i, // Wishbone byte address
    input wire [3:0] wb_sel_i, // Wishbone byte selects
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    output reg wb_ack_o, // Wishbone acknowledge
    output wire irq, // Level interrupt
    input wire [NCORE-1:0] dma_req, // DMA master requests
    input wire [NCORE-1:0] dma_we, // Request is a write to host memory
    input wire [NCORE-1:0] dma_desc, // Request moves a descriptor
    input wire [NCORE-1:0] dma_dir_tx, // Channel direction: 1 transmit
    input wire [NCORE*5-1:0] dma_chan, // Channel number per master
    input wire [NCORE*LENW-1:0] dma_len, // Words minus one per master
    input wire [NCORE*32-1:0] dma_addr, // Start address per master
    input wire [NCORE*32-1:0] dma_wdata, // Write word per master
    output wire [NCORE-1:0] dma_gnt, // Internal bus grant
    output reg [NCORE-1:0] dma_wnext, // Write word taken, present next
    output reg [NCORE-1:0] dma_rvalid, // Read word valid on dma_rdata
    output reg [31:0] dma_rdata, // Read word
    output reg [NCORE-1:0] dma_done, // Transfer finished
    output reg [NCORE-1:0] dma_refused, // Transfer refused, channel or core off
    input wire [1:0] bus_mode_select_pins, // Host bus mode select
    output wire demultiplexed_bus_mode, // Demultiplexed mode in force
    output reg host_req, // Host bus transaction frame
    output reg host_dstb, // Host bus data strobe
    output reg [31:0] host_addr, // Start address of the transaction
    output reg [3:0] host_cbe, // Command nibble, PCI mode only
    output reg host_wr_n_rd, // Direction, demultiplexed mode
    output reg host_burst, // Transaction is a burst
    output reg host_last, // Current word is the last
    output reg [31:0] host_wdata, // Host write data
    input wire host_ack, // Host word acknowledge, four-phase
    input wire [31:0] host_rdata // Host read data
);
    localparam S_IDLE = 4'b0001;
    localparam S_START = 4'b0010;
    localparam S_WORD = 4'b0100;
    localparam S_GAP = 4'b1000;

    reg [1:0] mode_meta_reg;
    reg [1:0] mode_reg;
    reg ack_meta_reg;
    reg ack_reg;
    reg [31:0] rdat_meta_reg;
    reg [31:0] rdat_reg;

    reg [31:0] config_reg;
    reg [7:0] status_reg;
    reg [7:0] status_next;
    reg [7:0] int_enable_reg;
    reg [31:0] ctrl_reg [0:NCORE-1];
    reg [31:0] rx_en_reg [0:NCORE-1];
    reg [31:0] tx_en_reg [0:NCORE-1];
    reg [15:0] count_reg [0:NCORE-1];

    reg [3:0] state_reg;
    reg [1:0] cur_reg;
    reg cur_we_reg;
    reg [LENW-1:0] left_reg;
    reg xfer_end;
    reg [31:0] wmask;
    reg [31:0] rd_val;
    reg [1:0] gidx;
    reg chan_ok;
    reg want_burst;
    integer c;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire core_hit = (wb_adr_i & `CORE_REGION_MASK) == `OFF_CORE_BASE;
    wire [1:0] core_idx = wb_adr_i[5:4];
    wire [3:0] core_off = wb_adr_i[3:0];
    wire burst_en = config_reg[`CFG_BURST_EN_BIT];

    assign demultiplexed_bus_mode = (mode_reg == `MODE_DEMULTIPLEXED_BUS_MODE);
    assign irq = |(status_reg & int_enable_reg);

    rr_arbiter #(
        .N(NCORE),
        .W(2)
    ) u_arb (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .req(dma_req),
        .xfer_end(xfer_end),
        .gnt(dma_gnt)
    );

    // Pin inputs pass two flip-flops
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {mode_meta_reg, mode_reg, ack_meta_reg, ack_reg} <= 6'h0;
            {rdat_meta_reg, rdat_reg} <= 64'h0;
        end
        else
        begin
            mode_meta_reg <= bus_mode_select_pins;
            mode_reg <= mode_meta_reg;
            {rdat_meta_reg, ack_meta_reg} <= {host_rdata, host_ack};
            {rdat_reg, ack_reg} <= {rdat_meta_reg, ack_meta_reg};
        end
    end

    // Granted master and the check of its channel enable
    always @*
    begin
        gidx = 2'h0;
        for (c = 0; c < NCORE; c = c + 1)
        begin
            if (dma_gnt[c])
            begin
                gidx = c[1:0];
            end
        end
        chan_ok = dma_dir_tx[gidx] ? tx_en_reg[gidx][dma_chan[gidx*5 +: 5]]
            : rx_en_reg[gidx][dma_chan[gidx*5 +: 5]];
        chan_ok = chan_ok & ctrl_reg[gidx][`CTRL_CORE_EN_BIT];
        // Payload always single; descriptors burst only when allowed
        want_burst = dma_desc[gidx] & burst_en & (dma_len[gidx*LENW +: LENW] != 0);
    end

    // Host bus master engine
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= S_IDLE;
            cur_reg <= 2'h0;
            cur_we_reg <= 1'b0;
            left_reg <= {LENW{1'b0}};
            xfer_end <= 1'b0;
            {host_req, host_dstb, host_wr_n_rd, host_burst, host_last} <= 5'h0;
            {host_addr, host_wdata, dma_rdata} <= 96'h0;
            host_cbe <= 4'h0;
            {dma_wnext, dma_rvalid, dma_done, dma_refused} <= {4*NCORE{1'b0}};
        end
        else
        begin
            xfer_end <= 1'b0;
            {dma_wnext, dma_rvalid, dma_done, dma_refused} <= {4*NCORE{1'b0}};
            case (state_reg)
                S_IDLE:
                begin
                    if (dma_gnt != {NCORE{1'b0}} && !xfer_end)
                    begin
                        cur_reg <= gidx;
                        cur_we_reg <= dma_we[gidx];
                        left_reg <= dma_len[gidx*LENW +: LENW];
                        host_addr <= dma_addr[gidx*32 +: 32];
                        host_burst <= want_burst;
                        if (chan_ok)
                        begin
                            state_reg <= S_START;
                        end
                        else
                        begin
                            dma_refused[gidx] <= 1'b1;
                            dma_done[gidx] <= 1'b1;
                            xfer_end <= 1'b1;
                        end
                    end
                end
                S_START:
                begin
                    // Device acts as master for every data and descriptor move
                    host_req <= 1'b1;
                    host_dstb <= 1'b1;
                    host_wr_n_rd <= cur_we_reg;
                    host_cbe <= demultiplexed_bus_mode ? 4'h0 :
                        cur_we_reg ? `CMD_MEM_WRITE :
                        host_burst ? `CMD_MEM_READ_MULT : `CMD_MEM_READ;
                    host_last <= (left_reg == 0) | ~host_burst;
                    host_wdata <= dma_wdata[cur_reg*32 +: 32];
                    state_reg <= S_WORD;
                end
                S_WORD:
                begin
                    if (ack_reg)
                    begin
                        host_dstb <= 1'b0;
                        if (cur_we_reg)
                        begin
                            dma_wnext[cur_reg] <= 1'b1;
                        end
                        else
                        begin
                            dma_rdata <= rdat_reg;
                            dma_rvalid[cur_reg] <= 1'b1;
                        end
                        state_reg <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (!ack_reg)
                    begin
                        if (left_reg == 0)
                        begin
                            host_req <= 1'b0;
                            host_last <= 1'b0;
                            dma_done[cur_reg] <= 1'b1;
                            xfer_end <= 1'b1;
                            state_reg <= S_IDLE;
                        end
                        else if (host_burst)
                        begin
                            // Address is not driven again within a burst
                            left_reg <= left_reg - 1'b1;
                            host_dstb <= 1'b1;
                            host_last <= (left_reg == 1);
                            host_wdata <= dma_wdata[cur_reg*32 +: 32];
                            state_reg <= S_WORD;
                        end
                        else
                        begin
                            // Split into single transactions, each with its own address
                            left_reg <= left_reg - 1'b1;
                            host_req <= 1'b0;
                            host_addr <= host_addr + 32'h4;
                            state_reg <= S_START;
                        end
                    end
                end
                default:
                begin
                    state_reg <= S_IDLE;
                    host_req <= 1'b0;
                    host_dstb <= 1'b0;
                end
            endcase
        end
    end

    // Sticky status: hardware set wins over a software clear
    always @*
    begin
        status_next = status_reg;
        if (wb_wr && wb_adr_i == `OFF_INT_CLEAR && wb_sel_i[0])
        begin
            status_next = status_next & ~wb_dat_i[7:0];
        end
        for (c = 0; c < NCORE; c = c + 1)
        begin
            if (dma_done[c] && !dma_refused[c])
            begin
                status_next[c*`ST_BITS_PER_CORE + `ST_DONE_BIT] = 1'b1;
            end
            if (dma_refused[c])
            begin
                status_next[c*`ST_BITS_PER_CORE + `ST_REFUSED_BIT] = 1'b1;
            end
        end
    end

    always @*
    begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        rd_val = 32'h0;
        if (core_hit)
        begin
            case (core_off)
                `OFF_CORE_CTRL: rd_val = ctrl_reg[core_idx];
                `OFF_RX_CHAN_EN: rd_val = rx_en_reg[core_idx];
                `OFF_TX_CHAN_EN: rd_val = tx_en_reg[core_idx];
                `OFF_XFER_COUNT: rd_val = {16'h0, count_reg[core_idx]};
                default: rd_val = 32'h0;
            endcase
        end
        else
        begin
            case (wb_adr_i)
                `OFF_CONFIG: rd_val = config_reg;
                `OFF_STATUS: rd_val = {24'h0, status_reg};
                `OFF_INT_ENABLE: rd_val = {24'h0, int_enable_reg};
                `OFF_MODE: rd_val = {30'h0, mode_reg};
                default: rd_val = 32'h0;
            endcase
        end
    end

    // Wishbone slave and register file
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            config_reg <= `CONFIG_RESET;
            status_reg <= `STATUS_RESET;
            int_enable_reg <= `INT_ENABLE_RESET;
            for (c = 0; c < NCORE; c = c + 1)
            begin
                ctrl_reg[c] <= `CTRL_RESET;
                rx_en_reg[c] <= `CHAN_EN_RESET;
                tx_en_reg[c] <= `CHAN_EN_RESET;
                count_reg[c] <= 16'h0;
            end
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
            begin
                wb_dat_o <= rd_val;
            end
            status_reg <= status_next;
            for (c = 0; c < NCORE; c = c + 1)
            begin
                count_reg[c] <= count_reg[c] + {15'h0, dma_done[c] & ~dma_refused[c]};
            end
            if (wb_wr && core_hit)
            begin
                case (core_off)
                    `OFF_CORE_CTRL:
                        ctrl_reg[core_idx] <= (ctrl_reg[core_idx] & ~wmask) | (wb_dat_i & wmask);
                    `OFF_RX_CHAN_EN:
                        rx_en_reg[core_idx] <= (rx_en_reg[core_idx] & ~wmask) | (wb_dat_i & wmask);
                    `OFF_TX_CHAN_EN:
                        tx_en_reg[core_idx] <= (tx_en_reg[core_idx] & ~wmask) | (wb_dat_i & wmask);
                    default:
                        config_reg <= config_reg;
                endcase
            end
            else if (wb_wr)
            begin
                case (wb_adr_i)
                    `OFF_CONFIG:
                        config_reg <= (config_reg & ~wmask) | (wb_dat_i & wmask);
                    `OFF_INT_ENABLE:
                        int_enable_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : int_enable_reg;
                    default:
                        config_reg <= config_reg;
                endcase
            end
        end
    end
endmodule // host_bus_interface_arbiter

// File: bench/hbi_chk.sv
/* Port checker of the host bus interface arbiter.
   Assumes binding to the design top and a single clock domain. */
`timescale 1ns/1ps
`include "hbi_defs.vh"
module hbi_chk #(
    parameter NCORE = 4,
    parameter LENW = 3
)(
    input wire mclk, // Clock
    input wire sys_rst, // Reset
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    input wire wb_ack_o, // Acknowledge
    input wire [NCORE-1:0] dma_req, // Requests
    input wire [NCORE-1:0] dma_gnt, // Grants
    input wire [NCORE-1:0] dma_done, // Finished
    input wire [1:0] bus_mode_select_pins, // Mode pins
    input wire demultiplexed_bus_mode, // Mode in force
    input wire host_req, // Frame
    input wire [31:0] host_addr, // Start address
    input wire [3:0] host_cbe, // Command
    input wire host_wr_n_rd, // Direction
    input wire host_burst // Burst
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    AST_GNT_ONEHOT: assert property ($onehot0(dma_gnt))
        else $error("more than one grant");
    AST_GNT_CAUSE: assert property ($rose(|dma_gnt) |-> |($past(dma_req) & dma_gnt))
        else $error("grant without request");
    AST_GNT_HOLD: assert property (|dma_gnt && !(|dma_done) |=> $stable(dma_gnt))
        else $error("grant moved mid transfer");
    AST_GNT_FREE: assert property (|dma_done |=> (dma_gnt & $past(dma_done)) == 4'h0)
        else $error("grant kept after done");
    AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("slave access not acknowledged");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    AST_HOST_GRANTED: assert property (host_req |-> |dma_gnt)
        else $error("host frame without grant");
    AST_BURST_ADDR: assert property (host_req && host_burst |=> !host_req || $stable(host_addr))
        else $error("address advanced inside burst");
    AST_DEMULTIPLEXED_BUS_MODE_CMD: assert property (host_req && demultiplexed_bus_mode |-> host_cbe == 4'h0)
        else $error("command nibble in demultiplexed_bus_mode mode");
    AST_PCI_CMD: assert property (host_req && !demultiplexed_bus_mode && !host_burst
        |-> host_cbe == (host_wr_n_rd ? `CMD_MEM_WRITE : `CMD_MEM_READ))
        else $error("wrong single command");
    AST_MODE_SYNC: assert property ($stable(bus_mode_select_pins)[*4]
        |-> demultiplexed_bus_mode == (bus_mode_select_pins == `MODE_DEMULTIPLEXED_BUS_MODE))
        else $error("mode does not follow pins");

    COV_BURST: cover property (host_req && host_burst);
    COV_DEMULTIPLEXED_BUS_MODE: cover property (host_req && demultiplexed_bus_mode);
    COV_DONE: cover property (|dma_done);
endmodule // hbi_chk

bind host_bus_interface_arbiter hbi_chk #(.NCORE(NCORE), .LENW(LENW)) chk (.*);

// File: bench/host_mem_model.sv
/* Host memory model on the far side of the host bus.
   Assumes the four-phase word handshake; a read word equals its own address. */
`timescale 1ns/1ps
module host_mem_model (
    input wire mclk, // Clock
    input wire sys_rst, // Reset
    input wire slow, // Add wait cycles
    input wire host_req, // Frame
    input wire host_dstb, // Word strobe
    input wire [31:0] host_addr, // Start address
    input wire host_wr_n_rd, // Direction
    input wire [31:0] host_wdata, // Write word
    output reg host_ack, // Word acknowledge
    output reg [31:0] host_rdata, // Read word
    output reg [31:0] last_wdata // Last word written
);
    reg [7:0] word_reg;
    reg [2:0] wait_reg;
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host_ack <= 1'b0;
            host_rdata <= 32'h0;
            last_wdata <= 32'h0;
            word_reg <= 8'h00;
            wait_reg <= 3'h0;
        end
        else if (host_dstb && !host_ack)
        begin
            wait_reg <= wait_reg + 3'h1;
            if (wait_reg == 3'h0)
                host_rdata <= host_addr + {22'h0, word_reg, 2'b00};
            if (wait_reg == (slow ? 3'h4 : 3'h1))
            begin
                host_ack <= 1'b1;
                wait_reg <= 3'h0;
                if (host_wr_n_rd)
                    last_wdata <= host_wdata;
            end
        end
        else if (host_ack && !host_dstb)
        begin
            host_ack <= 1'b0;
            host_rdata <= ~host_rdata; // Released lines lose the word
            word_reg <= word_reg + 8'h01;
        end
        else if (!host_req)
            word_reg <= 8'h00;
    end
endmodule // host_mem_model

// File: bench/tb_top.sv
/* Self-checking bench of the host bus interface arbiter.
   Assumes the host memory model as far side and one 50 MHz clock. */
`timescale 1ns/1ps
`include "hbi_defs.vh"
module tb_top;
    reg mclk = 1'b0;
    reg sys_rst = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, slow = 1'b0;
    reg saw_host = 1'b0, saw_burst = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'h0, dma_req = 4'h0, dma_we = 4'h0, dma_desc = 4'h0, dma_dir_tx = 4'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg [19:0] dma_chan = 20'h0;
    reg [11:0] dma_len = 12'h0;
    reg [127:0] dma_addr = 128'h0, dma_wdata = 128'h0;
    reg [1:0] bus_mode_select_pins = 2'h0;
    wire [31:0] wb_dat_o, dma_rdata, host_addr, host_wdata, host_rdata, last_wdata;
    wire wb_ack_o, irq, demultiplexed_bus_mode, host_req, host_dstb, host_wr_n_rd;
    wire host_burst, host_last, host_ack;
    wire [3:0] dma_gnt, dma_wnext, dma_rvalid, dma_done, dma_refused, host_cbe;
    integer mismatches = 0, n_compared = 0;

    always #10 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (host_req)
            saw_host <= 1'b1;
        if (host_req && host_burst)
            saw_burst <= 1'b1;
    end

    host_bus_interface_arbiter #(.NCORE(4), .NCHAN(32), .LENW(3)) dut (.mclk, .sys_rst,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .irq, .dma_req, .dma_we, .dma_desc, .dma_dir_tx, .dma_chan, .dma_len, .dma_addr,
        .dma_wdata, .dma_gnt, .dma_wnext, .dma_rvalid, .dma_rdata, .dma_done, .dma_refused,
        .bus_mode_select_pins, .demultiplexed_bus_mode, .host_req, .host_dstb, .host_addr,
        .host_cbe, .host_wr_n_rd, .host_burst, .host_last, .host_wdata, .host_ack, .host_rdata);
    host_mem_model partner (.*);

    task ck(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do
            @(posedge mclk);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask

    task wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task rd(input [7:0] a, input [31:0] e);
        reg [31:0] q;
        wb(1'b0, a, 32'h0, q);
        ck(q, e);
    endtask

    task dma(input [1:0] c, input w, input ds, input [2:0] n, input [31:0] a, output fr);
        integer i;
        i = 0;
        dma_we[c] <= w;
        dma_dir_tx[c] <= w;
        dma_desc[c] <= ds;
        dma_chan[c*5 +: 5] <= 5'h1f;
        dma_len[c*3 +: 3] <= n;
        dma_addr[c*32 +: 32] <= a;
        dma_wdata[c*32 +: 32] <= 32'h5000_0000;
        dma_req[c] <= 1'b1;
        @(posedge mclk);
        while (dma_done[c] !== 1'b1)
        begin
            if (dma_gnt[c] === 1'b1)
                dma_req[c] <= 1'b0;
            if (dma_rvalid[c] === 1'b1)
            begin
                ck(dma_rdata, a + 4 * i);
                i = i + 1;
            end
            if (dma_wnext[c] === 1'b1)
            begin
                i = i + 1;
                dma_wdata[c*32 +: 32] <= 32'h5000_0000 + i;
            end
            @(posedge mclk);
        end
        fr = dma_refused[c];
        if (fr !== 1'b1)
            ck(i, n + 1);
        if (w && fr !== 1'b1)
            ck(last_wdata, 32'h5000_0000 + n);
    endtask

    task t_regs;
        integer c;
        rd(`OFF_CONFIG, `CONFIG_RESET);
        rd(8'hf0, 32'h0);
        for (c = 0; c < 4; c = c + 1)
        begin
            rd(8'h40 + c * 16, `CTRL_RESET);
            rd(8'h44 + c * 16, `CHAN_EN_RESET);
            wr(8'h48 + c * 16, 32'h1234_0000 + c);
        end
        for (c = 0; c < 4; c = c + 1)
        begin
            rd(8'h48 + c * 16, 32'h1234_0000 + c);
            wr(8'h48 + c * 16, `CHAN_EN_RESET);
        end
    endtask

    task t_mode;
        integer m;
        reg fr;
        for (m = 3; m >= 0; m = m - 1)
        begin
            bus_mode_select_pins <= m[1:0];
            repeat (4) @(posedge mclk);
            ck(demultiplexed_bus_mode, m == 1);
            if (m == 1)
                dma(2'd0, 1'b1, 1'b0, 3'h1, 32'h0000_0400, fr);
        end
    endtask

    task t_burst;
        reg fr;
        saw_burst = 1'b0;
        dma(2'd1, 1'b0, 1'b1, 3'h3, 32'h0000_1000, fr);
        ck(saw_burst, 1'b1);
        saw_burst = 1'b0;
        dma(2'd0, 1'b0, 1'b0, 3'h2, 32'h0000_2000, fr);
        ck(saw_burst, 1'b0);
        wr(`OFF_CONFIG, 32'h0);
        saw_burst = 1'b0;
        dma(2'd1, 1'b0, 1'b1, 3'h7, 32'h0000_3000, fr);
        ck(saw_burst, 1'b0);
        rd(8'h5c, 32'h2);
        wr(`OFF_CONFIG, `CONFIG_RESET);
        slow <= 1'b1;
        dma(2'd2, 1'b1, 1'b1, 3'h7, 32'h0000_4000, fr);
        ck(saw_burst, 1'b1);
        slow <= 1'b0;
    endtask

    task t_rr;
        integer k, g, p;
        p = 0;
        dma_we <= 4'h0;
        dma_desc <= 4'h0;
        dma_len <= 12'h0;
        dma_req <= 4'hf;
        for (k = 0; k < 4; k = k + 1)
        begin
            do
                @(posedge mclk);
            while (dma_done === 4'h0);
            g = dma_done[1] + 2 * dma_done[2] + 3 * dma_done[3];
            dma_req[g] <= 1'b0;
            if (k > 0)
                ck(g, (p + 1) % 4);
            p = g;
        end
    endtask

    task t_refuse;
        reg fr;
        wr(`OFF_INT_CLEAR, 32'hff);
        wr(8'h70, 32'h0);
        saw_host = 1'b0;
        dma(2'd3, 1'b0, 1'b0, 3'h0, 32'h0000_5000, fr);
        ck(fr, 1'b1);
        ck(saw_host, 1'b0);
        rd(`OFF_STATUS, 32'h80);
        ck(irq, 1'b0);
        wr(`OFF_INT_ENABLE, 32'h80);
        ck(irq, 1'b1);
        wr(`OFF_INT_ENABLE, 32'h0);
        ck(irq, 1'b0);
        wr(`OFF_INT_ENABLE, 32'h80);
        wr(`OFF_INT_CLEAR, 32'h80);
        ck(irq, 1'b0);
        wr(8'h70, `CTRL_RESET);
        wr(8'h44, 32'h7fff_ffff);
        dma(2'd0, 1'b0, 1'b0, 3'h0, 32'h0000_6000, fr);
        ck(fr, 1'b1);
        wr(8'h44, `CHAN_EN_RESET);
        dma(2'd3, 1'b0, 1'b0, 3'h0, 32'h0000_7000, fr);
        rd(`OFF_STATUS, 32'h42);
    endtask

    task wrap_up;
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs;
        t_mode;
        t_burst;
        t_rr;
        t_refuse;
        wrap_up;
    end

    initial
    begin
        #400000;
        mismatches = mismatches + 1;
        wrap_up;
    end
endmodule // tb_top
